// ==== tafq_alarm.sv ====
// Purpose: Result store, limit compare, fault queue and alarm output.
// Assumes: All inputs come from logic on clk_i; event inputs are pulses.
// Notes:   Nonvolatile settings are loaded one edge after reset release.

module tafq_alarm
(
	input  wire logic                             clk_i,
	input  wire logic                             rst_n_i,
	// Converter result
	input  wire logic                             conv_valid_i,
	input  wire logic [tafq_pkg::TAFQ_TEMP_W-1:0] conv_temp_i,
	input  wire logic                             conv_oneshot_i,
	// Working configuration write
	input  wire logic                             cfg_wr_i,
	input  wire logic                             resolution_sel_hi_i,
	input  wire logic                             resolution_sel_lo_i,
	input  wire logic                             queue_depth_hi_i,
	input  wire logic                             queue_depth_lo_i,
	input  wire logic                             alarm_polarity_i,
	input  wire logic                             alarm_behaviour_sel_i,
	input  wire logic                             power_down_bit_i,
	// Working limit write
	input  wire logic                             lim_wr_i,
	input  wire logic [tafq_pkg::TAFQ_TEMP_W-1:0] upper_limit_i,
	input  wire logic [tafq_pkg::TAFQ_TEMP_W-1:0] lower_limit_i,
	// Nonvolatile copies
	input  wire logic                             nv_resolution_sel_hi_i,
	input  wire logic                             nv_resolution_sel_lo_i,
	input  wire logic                             nv_queue_depth_hi_i,
	input  wire logic                             nv_queue_depth_lo_i,
	input  wire logic                             nv_alarm_polarity_i,
	input  wire logic                             nv_alarm_behaviour_sel_i,
	input  wire logic [tafq_pkg::TAFQ_TEMP_W-1:0] nv_upper_limit_i,
	input  wire logic [tafq_pkg::TAFQ_TEMP_W-1:0] nv_lower_limit_i,
	// Host link events
	input  wire logic                             reg_read_i,
	input  wire logic                             ara_answer_i,
	input  wire logic                             gcall_reset_i,
	// Outputs
	output logic      [tafq_pkg::TAFQ_TEMP_W-1:0] temp_result_o,
	output logic      [tafq_pkg::TAFQ_CNT_W-1:0]  fault_count_o,
	output logic      [1:0]                       resolution_sel_o,
	output logic      [1:0]                       queue_depth_o,
	output logic                                  alarm_polarity_o,
	output logic                                  alarm_behaviour_sel_o,
	output logic                                  power_down_bit_o,
	output logic      [tafq_pkg::TAFQ_TEMP_W-1:0] upper_limit_o,
	output logic      [tafq_pkg::TAFQ_TEMP_W-1:0] lower_limit_o,
	output logic                                  alarm_active_o,
	output logic                                  alarm_o
);
	import tafq_pkg::*;

	// ==========================================================
	// Storage
	logic                   load_req_reg;     // Reload after reset
	logic [1:0]             res_reg;          // Working resolution
	logic [1:0]             que_reg;          // Working queue code
	logic                   pol_reg;          // Working polarity
	tafq_mode_t             mode_reg;         // Working behaviour
	logic                   sd_reg;           // Working shutdown bit
	logic [TAFQ_TEMP_W-1:0] upper_reg;        // Working upper limit
	logic [TAFQ_TEMP_W-1:0] lower_reg;        // Working lower limit
	logic [TAFQ_TEMP_W-1:0] temp_reg;         // Stored result
	logic [TAFQ_CNT_W-1:0]  fault_cnt_reg;    // Consecutive faults
	logic                   alarm_reg;        // Alarm asserted
	logic                   expect_hi_reg;    // Next alarm wants high
	logic [TAFQ_PLS_W-1:0]  pulse_cnt_reg;    // One-shot pulse timer
	logic                   alarm_pin_reg;    // Alarm pin level

	// ==========================================================
	// Combinational terms
	logic                   load;             // Reload this edge
	logic [TAFQ_TEMP_W-1:0] temp_next;        // Masked new result
	logic [TAFQ_CNT_W-1:0]  depth;            // Selected queue depth
	logic                   hi_hit;           // At or above upper
	logic                   lo_hit;           // At or below lower
	logic [TAFQ_CNT_W-1:0]  cnt_inc;          // Saturated increment
	logic [TAFQ_CNT_W-1:0]  fault_cnt_next;   // Counter after result
	logic                   valid_hi;         // Valid high condition
	logic                   valid_lo;         // Valid low condition
	logic                   sd_enter;         // Shutdown entered
	logic                   int_set;          // Interrupt alarm set
	logic                   int_clr;          // Interrupt alarm clear
	logic                   pulse_start;      // One-shot pulse begins
	logic                   pulse_end;        // One-shot pulse ends

	// Reload on reset release or general-call reset
	assign load = load_req_reg || gcall_reset_i;

	// Result compare and fault queue arithmetic
	always_comb begin
		temp_next = conv_temp_i & TAFQ_RES_MASK[res_reg];
		depth     = TAFQ_QUEUE_DEPTH[que_reg];
		hi_hit    = $signed(temp_next) >= $signed(upper_reg);
		lo_hit    = $signed(temp_next) <= $signed(lower_reg);
		if (fault_cnt_reg >= depth) begin
			cnt_inc = depth;
		end else begin
			cnt_inc = fault_cnt_reg + TAFQ_CNT_ONE;
		end
		if (hi_hit || lo_hit) begin
			fault_cnt_next = cnt_inc;
		end else begin
			fault_cnt_next = TAFQ_CNT_ZERO;
		end
	end

	// Valid conditions; a high hit wins if the limits cross
	assign valid_hi = conv_valid_i && hi_hit && (cnt_inc == depth);
	assign valid_lo = conv_valid_i && lo_hit && !hi_hit
		&& (cnt_inc == depth);

	// Shutdown entry is a write turning the bit on
	assign sd_enter = cfg_wr_i && power_down_bit_i && !sd_reg;

	// Interrupt events: only the expected kind sets the alarm
	assign int_set = expect_hi_reg ? valid_hi : valid_lo;
	assign int_clr = reg_read_i || ara_answer_i || sd_enter
		|| pulse_end;
	assign pulse_start = (mode_reg == TAFQ_MODE_INT) && int_set
		&& conv_oneshot_i && sd_reg;
	assign pulse_end = (pulse_cnt_reg == TAFQ_PLS_ONE);

	// ==========================================================
	// Load request: set by reset, used once after release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_req_reg <= 1'b1;
		end else begin
			load_req_reg <= 1'b0;
		end
	end

	// Working configuration register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			res_reg  <= TAFQ_RES_RST;
			que_reg  <= TAFQ_QUE_RST;
			pol_reg  <= TAFQ_POL_RST;
			mode_reg <= TAFQ_MODE_CMP;
			sd_reg   <= 1'b0;
		end else if (load) begin
			// Copy nonvolatile settings
			res_reg  <= {nv_resolution_sel_hi_i,
				nv_resolution_sel_lo_i};
			que_reg  <= {nv_queue_depth_hi_i,
				nv_queue_depth_lo_i};
			pol_reg  <= nv_alarm_polarity_i;
			mode_reg <= tafq_mode_t'(nv_alarm_behaviour_sel_i);
			sd_reg   <= 1'b0;
		end else if (cfg_wr_i) begin
			// Host write of the working settings
			res_reg  <= {resolution_sel_hi_i, resolution_sel_lo_i};
			que_reg  <= {queue_depth_hi_i, queue_depth_lo_i};
			pol_reg  <= alarm_polarity_i;
			mode_reg <= tafq_mode_t'(alarm_behaviour_sel_i);
			sd_reg   <= power_down_bit_i;
		end
	end

	// Working limit registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upper_reg <= TAFQ_TEMP_RST;
			lower_reg <= TAFQ_TEMP_RST;
		end else if (load) begin
			upper_reg <= nv_upper_limit_i;
			lower_reg <= nv_lower_limit_i;
		end else if (lim_wr_i) begin
			upper_reg <= upper_limit_i;
			lower_reg <= lower_limit_i;
		end
	end

	// Result register, overwritten by each conversion
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			temp_reg <= TAFQ_TEMP_RST;
		end else if (conv_valid_i) begin
			temp_reg <= temp_next;
		end
	end

	// Fault counter; shutdown alone never touches it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_cnt_reg <= TAFQ_CNT_ZERO;
		end else if (load) begin
			fault_cnt_reg <= TAFQ_CNT_ZERO;
		end else if (conv_valid_i) begin
			fault_cnt_reg <= fault_cnt_next;
		end
	end

	// Alarm state and high/low alternation
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alarm_reg     <= 1'b0;
			expect_hi_reg <= 1'b1;
		end else if (load) begin
			// General-call reset drops the alarm in either mode
			alarm_reg     <= 1'b0;
			expect_hi_reg <= 1'b1;
		end else if (mode_reg == TAFQ_MODE_CMP) begin
			// Only valid limit conditions move the alarm
			if (valid_hi) begin
				alarm_reg     <= 1'b1;
				expect_hi_reg <= 1'b0;
			end else if (valid_lo) begin
				alarm_reg     <= 1'b0;
				expect_hi_reg <= 1'b1;
			end
		end else begin
			// Interrupt: a set in the clearing cycle wins
			if (int_set) begin
				alarm_reg     <= 1'b1;
				expect_hi_reg <= !expect_hi_reg;
			end else if (int_clr) begin
				alarm_reg <= 1'b0;
			end
		end
	end

	// One-shot pulse timer for interrupt behaviour
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_cnt_reg <= TAFQ_PLS_ZERO;
		end else if (load || mode_reg == TAFQ_MODE_CMP) begin
			pulse_cnt_reg <= TAFQ_PLS_ZERO;
		end else if (pulse_start) begin
			pulse_cnt_reg <= TAFQ_PULSE_CNT;
		end else if (int_clr) begin
			// Any clear stops the timer so it cannot drop a later alarm
			pulse_cnt_reg <= TAFQ_PLS_ZERO;
		end else if (pulse_cnt_reg != TAFQ_PLS_ZERO) begin
			pulse_cnt_reg <= pulse_cnt_reg - TAFQ_PLS_ONE;
		end
	end

	// Alarm pin level after polarity
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alarm_pin_reg <= 1'b1;
		end else begin
			alarm_pin_reg <= pol_reg ? alarm_reg : !alarm_reg;
		end
	end

	// ==========================================================
	// Outputs
	assign temp_result_o         = temp_reg;
	assign fault_count_o         = fault_cnt_reg;
	assign resolution_sel_o      = res_reg;
	assign queue_depth_o         = que_reg;
	assign alarm_polarity_o      = pol_reg;
	assign alarm_behaviour_sel_o = mode_reg;
	assign power_down_bit_o      = sd_reg;
	assign upper_limit_o         = upper_reg;
	assign lower_limit_o         = lower_reg;
	assign alarm_active_o        = alarm_reg;
	assign alarm_o               = alarm_pin_reg;

	// ==========================================================
	// Checks
	localparam int PULSE_MAX = TAFQ_PULSE_CYC + 1; // Pulse bound

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	result_store_a: assert property (
		conv_valid_i |=> temp_result_o == $past(temp_next))
		else $error("result not stored");

	res_reload_a: assert property (
		load_req_reg |=> resolution_sel_o ==
			$past({nv_resolution_sel_hi_i, nv_resolution_sel_lo_i}))
		else $error("resolution not reloaded");

	mode_reload_a: assert property (
		load |=> alarm_polarity_o == $past(nv_alarm_polarity_i)
			&& alarm_behaviour_sel_o == $past(nv_alarm_behaviour_sel_i))
		else $error("polarity or behaviour not reloaded");

	queue_reload_a: assert property (
		load_req_reg |=> queue_depth_o ==
			$past({nv_queue_depth_hi_i, nv_queue_depth_lo_i}))
		else $error("queue setting not reloaded");

	count_clear_a: assert property (
		conv_valid_i && !load && !hi_hit && !lo_hit
			|=> fault_count_o == TAFQ_CNT_ZERO)
		else $error("fault counter not cleared");

	count_hold_a: assert property (
		!conv_valid_i && !load |=> $stable(fault_count_o))
		else $error("fault counter moved without result");

	count_sat_a: assert property (
		conv_valid_i && !load && !cfg_wr_i && hi_hit
			|=> fault_count_o <= $past(depth) && fault_count_o != 0)
		else $error("fault counter past depth");

	cmp_set_a: assert property (
		mode_reg == TAFQ_MODE_CMP && valid_hi && !load
			|=> alarm_active_o ##1 alarm_o == $past(alarm_polarity_o))
		else $error("comparator alarm not set");

	cmp_hold_a: assert property (
		mode_reg == TAFQ_MODE_CMP && !valid_hi && !valid_lo && !load
			|=> $stable(alarm_active_o))
		else $error("comparator alarm moved without fault");

	int_clear_a: assert property (
		mode_reg == TAFQ_MODE_INT && !int_set && !load
			&& (reg_read_i || ara_answer_i || sd_enter)
			|=> !alarm_active_o)
		else $error("interrupt alarm not cleared");

	first_high_a: assert property (
		load ##1 (mode_reg == TAFQ_MODE_INT && !valid_hi && !load)
			|=> !alarm_active_o)
		else $error("first interrupt alarm without high fault");

	gcall_clear_a: assert property (
		gcall_reset_i |=> !alarm_active_o)
		else $error("general-call reset left alarm on");

	pulse_len_a: assert property (
		pulse_start && !load |=> alarm_active_o
			##[1:PULSE_MAX] !alarm_active_o)
		else $error("one-shot pulse not released");

	pin_level_a: assert property (
		alarm_active_o && !alarm_polarity_o && $stable(alarm_active_o)
			&& $stable(alarm_polarity_o) |-> !alarm_o)
		else $error("active-low alarm pin not low");

endmodule

// ==== tafq_host_model.sv ====
// Purpose: Host controller stand-in that issues link events and limits.
// Assumes: The bench calls the tasks below; outputs move on clk_i edges.
// Notes:   Idle limit lines show the inverse of the last written value.
module tafq_host_model
(
	input  wire logic                             clk_i,
	output logic                                  reg_read_o,
	output logic                                  ara_answer_o,
	output logic                                  gcall_reset_o,
	output logic                                  lim_wr_o,
	output logic      [tafq_pkg::TAFQ_TEMP_W-1:0] upper_limit_o,
	output logic      [tafq_pkg::TAFQ_TEMP_W-1:0] lower_limit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import tafq_pkg::*;

	// ==========================================================
	// Idle levels from time zero
	initial begin
		reg_read_o    = 1'b0;
		ara_answer_o  = 1'b0;
		gcall_reset_o = 1'b0;
		lim_wr_o      = 1'b0;
		upper_limit_o = 12'h5a5;
		lower_limit_o = 12'ha5a;
	end

	// One-cycle event: 0 register read, 1 alert answer, 2 general call
	task automatic event_pulse(input int kind);
		@(posedge clk_i);
		case (kind)
			0: reg_read_o <= 1'b1;
			1: ara_answer_o <= 1'b1;
			default: gcall_reset_o <= 1'b1;
		endcase
		@(posedge clk_i);
		reg_read_o    <= 1'b0;
		ara_answer_o  <= 1'b0;
		gcall_reset_o <= 1'b0;
	endtask

	// Limit write; an out-of-order pair is never sent
	task automatic write_limits(input logic signed [11:0] up, lo);
		if (up > lo) begin
			@(posedge clk_i);
			lim_wr_o      <= 1'b1;
			upper_limit_o <= up;
			lower_limit_o <= lo;
			@(posedge clk_i);
			lim_wr_o      <= 1'b0;
			upper_limit_o <= ~up;
			lower_limit_o <= ~lo;
		end
	endtask

endmodule

// ==== tafq_pkg.sv ====
// Purpose: Shared constants and types for the temperature alarm block.
// Assumes: 12-bit two's complement results in 0.0625 degree steps.
// Notes:   Working and nonvolatile settings share these encodings.
package tafq_pkg;

	// ==========================================================
	// Widths
	localparam int TAFQ_TEMP_W = 12; // Result and limit width
	localparam int TAFQ_CNT_W  = 3;  // Fault counter width
	localparam int TAFQ_PLS_W  = 7;  // Alarm pulse counter width

	// ==========================================================
	// Reset values of working settings before the nonvolatile load, and counter constants
	localparam logic [1:0]             TAFQ_RES_RST  = 2'h0;
	localparam logic [1:0]             TAFQ_QUE_RST  = 2'h0;
	localparam logic                   TAFQ_POL_RST  = 1'h0;
	localparam logic [TAFQ_TEMP_W-1:0] TAFQ_TEMP_RST = 12'h000;
	localparam logic [TAFQ_CNT_W-1:0]  TAFQ_CNT_ZERO = 3'h0;
	localparam logic [TAFQ_CNT_W-1:0]  TAFQ_CNT_ONE  = 3'h1;
	localparam logic [TAFQ_PLS_W-1:0]  TAFQ_PLS_ZERO = 7'h00;
	localparam logic [TAFQ_PLS_W-1:0]  TAFQ_PLS_ONE  = 7'h01;

	// ==========================================================
	// Resolution code to kept result bits: 9, 10, 11, 12 bits
	localparam logic [TAFQ_TEMP_W-1:0] TAFQ_RES_MASK [4] =
		'{12'hff8, 12'hffc, 12'hffe, 12'hfff};

	// Queue code to consecutive faults needed: 1, 2, 4, 6
	localparam logic [TAFQ_CNT_W-1:0] TAFQ_QUEUE_DEPTH [4] =
		'{3'h1, 3'h2, 3'h4, 3'h6};

	// ==========================================================
	// Timing: one-shot interrupt pulse width
	localparam int TAFQ_CLK_NS   = 10;   // Clock period in ns
	localparam int TAFQ_PULSE_NS = 1000; // Least pulse width in ns
	localparam int TAFQ_PULSE_CYC =
		(TAFQ_PULSE_NS + TAFQ_CLK_NS - 1) / TAFQ_CLK_NS;
	localparam logic [TAFQ_PLS_W-1:0] TAFQ_PULSE_CNT =
		TAFQ_PLS_W'(TAFQ_PULSE_CYC);

	// ==========================================================
	// Alarm behaviour selection
	typedef enum logic {
		TAFQ_MODE_CMP = 1'b0, // Comparator behaviour
		TAFQ_MODE_INT = 1'b1  // Interrupt behaviour
	} tafq_mode_t;

endpackage

// ==== tafq_tb.sv ====
// Purpose: Self-checking bench for the alarm and fault queue block.
// Assumes: Inputs move by non-blocking assignment on rising clk_i edges.
// Notes:   A small integer model predicts every result and alarm level.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tafq_pkg::*;

	// ==========================================================
	// Design inputs and outputs
	logic clk_i, rst_n_i, conv_valid_i, conv_oneshot_i, cfg_wr_i;
	logic resolution_sel_hi_i, resolution_sel_lo_i, queue_depth_hi_i;
	logic queue_depth_lo_i, alarm_polarity_i, alarm_behaviour_sel_i;
	logic power_down_bit_i, lim_wr_i, reg_read_i, ara_answer_i;
	logic nv_resolution_sel_hi_i, nv_resolution_sel_lo_i, gcall_reset_i;
	logic nv_queue_depth_hi_i, nv_queue_depth_lo_i, nv_alarm_polarity_i;
	logic nv_alarm_behaviour_sel_i, alarm_polarity_o, alarm_behaviour_sel_o;
	logic power_down_bit_o, alarm_active_o, alarm_o;
	logic [TAFQ_TEMP_W-1:0] conv_temp_i, upper_limit_i, lower_limit_i;
	logic [TAFQ_TEMP_W-1:0] nv_upper_limit_i, nv_lower_limit_i;
	logic [TAFQ_TEMP_W-1:0] temp_result_o, upper_limit_o, lower_limit_o;
	logic [TAFQ_CNT_W-1:0]  fault_count_o;
	logic [1:0]             resolution_sel_o, queue_depth_o;
	// Model state
	int m_res, m_que, m_pol, m_mode, m_sd, m_cnt, m_act, m_exph;
	logic signed [11:0] m_up, m_lo;
	logic [11:0]        m_tmp;
	int depth_q[$] = '{1, 2, 4, 6};
	int num_errors, samples_checked;
	int seed = 76476;

	tafq_alarm dut_u (
		.clk_i, .rst_n_i, .conv_valid_i, .conv_temp_i, .conv_oneshot_i,
		.cfg_wr_i, .resolution_sel_hi_i, .resolution_sel_lo_i,
		.queue_depth_hi_i, .queue_depth_lo_i, .alarm_polarity_i,
		.alarm_behaviour_sel_i, .power_down_bit_i, .lim_wr_i,
		.upper_limit_i, .lower_limit_i, .nv_resolution_sel_hi_i,
		.nv_resolution_sel_lo_i, .nv_queue_depth_hi_i, .nv_queue_depth_lo_i,
		.nv_alarm_polarity_i, .nv_alarm_behaviour_sel_i, .nv_upper_limit_i,
		.nv_lower_limit_i, .reg_read_i, .ara_answer_i, .gcall_reset_i,
		.temp_result_o, .fault_count_o, .resolution_sel_o, .queue_depth_o,
		.alarm_polarity_o, .alarm_behaviour_sel_o, .power_down_bit_o,
		.upper_limit_o, .lower_limit_o, .alarm_active_o, .alarm_o
	);

	tafq_host_model host_u (
		.clk_i, .reg_read_o(reg_read_i), .ara_answer_o(ara_answer_i),
		.gcall_reset_o(gcall_reset_i), .lim_wr_o(lim_wr_i),
		.upper_limit_o(upper_limit_i), .lower_limit_o(lower_limit_i)
	);

	// ==========================================================
	// Clock and watchdog
	always #5 clk_i = ~clk_i;

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		final_report();
	end

	// ==========================================================
	// Checking helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Result, count and alarm state, then the pin one edge later
	task automatic chk_st();
		#1;
		chk(temp_result_o, m_tmp);
		chk(fault_count_o, m_cnt);
		chk(alarm_active_o, m_act);
		@(posedge clk_i);
		#1;
		chk(alarm_o, m_pol ? m_act : !m_act);
	endtask

	task automatic chk_cfg();
		chk(resolution_sel_o, m_res);
		chk(queue_depth_o, m_que);
		chk(alarm_polarity_o, m_pol);
		chk(alarm_behaviour_sel_o, m_mode);
		chk(power_down_bit_o, m_sd);
		chk(upper_limit_o, $unsigned(m_up));
		chk(lower_limit_o, $unsigned(m_lo));
	endtask

	// Working copy from the nonvolatile inputs, as after reset
	task automatic nv_load();
		m_res  = {nv_resolution_sel_hi_i, nv_resolution_sel_lo_i};
		m_que  = {nv_queue_depth_hi_i, nv_queue_depth_lo_i};
		m_pol  = nv_alarm_polarity_i;
		m_mode = nv_alarm_behaviour_sel_i;
		m_up   = nv_upper_limit_i;
		m_lo   = nv_lower_limit_i;
		{m_sd, m_cnt, m_act, m_exph} = {32'd0, 32'd0, 32'd0, 32'd1};
	endtask

	// ==========================================================
	// Stimulus tasks with model update
	task automatic conv(input logic [11:0] t, input logic os);
		logic signed [11:0] v;
		logic               hi;
		logic               lw;
		int                 d;
		v = t & ~(12'h7 >> m_res);
		hi = v >= m_up;
		lw = v <= m_lo;
		d = depth_q[m_que];
		m_cnt = (hi || lw) ? ((m_cnt + 1 > d) ? d : m_cnt + 1) : 0;
		if ((hi || lw) && m_cnt == d) begin
			if (m_mode == 0) begin
				m_act  = hi;
				m_exph = !hi;
			end else if (hi == m_exph) begin
				m_act  = 1;
				m_exph = !hi;
			end
		end
		m_tmp = v;
		@(posedge clk_i);
		conv_valid_i   <= 1'b1;
		conv_temp_i    <= t;
		conv_oneshot_i <= os;
		@(posedge clk_i);
		conv_valid_i   <= 1'b0;
		conv_oneshot_i <= 1'b0;
		chk_st();
	endtask

	task automatic cfg(input int r, q, p, md, sd);
		@(posedge clk_i);
		cfg_wr_i <= 1'b1;
		{resolution_sel_hi_i, resolution_sel_lo_i} <= 2'(r);
		{queue_depth_hi_i, queue_depth_lo_i} <= 2'(q);
		alarm_polarity_i      <= 1'(p);
		alarm_behaviour_sel_i <= 1'(md);
		power_down_bit_i      <= 1'(sd);
		@(posedge clk_i);
		cfg_wr_i <= 1'b0;
		if (sd != 0 && m_sd == 0 && m_mode == 1)
			m_act = 0;
		{m_res, m_que, m_pol, m_mode, m_sd} = {r, q, p, md, sd};
		chk_st();
		chk_cfg();
	endtask

	// Host event: 0 read, 1 alert answer, 2 general-call reset
	task automatic ev(input int kind);
		host_u.event_pulse(kind);
		if (kind == 2)
			nv_load();
		else if (m_mode == 1)
			m_act = 0;
		chk_st();
		chk_cfg();
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{clk_i, rst_n_i, conv_valid_i, conv_oneshot_i, cfg_wr_i} = '0;
		{resolution_sel_hi_i, resolution_sel_lo_i, power_down_bit_i} = '0;
		{queue_depth_hi_i, queue_depth_lo_i, alarm_polarity_i} = '0;
		{alarm_behaviour_sel_i, conv_temp_i} = '0;
		{nv_resolution_sel_hi_i, nv_resolution_sel_lo_i} = 2'h1;
		{nv_queue_depth_hi_i, nv_queue_depth_lo_i} = 2'h1;
		{nv_alarm_polarity_i, nv_alarm_behaviour_sel_i} = 2'h2;
		nv_upper_limit_i = 12'h190;
		nv_lower_limit_i = 12'h0a0;
		m_tmp = 12'h000;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		nv_load();
		chk_st();
		chk_cfg();
		$display("test reset_load done");
		// Random results at every resolution
		for (int r = 0; r < 4; r++) begin
			cfg(r, 0, 1, 0, 0);
			repeat (3) conv(12'($random(seed)), 1'b0);
		end
		$display("test resolution done");
		// Comparator queue at every depth, exact limit values
		host_u.write_limits(12'h190, 12'h0a0);
		m_up = 12'h190;
		m_lo = 12'h0a0;
		for (int q = 0; q < 4; q++) begin
			cfg(3, q, q % 2, 0, 0);
			conv(12'h100, 1'b0);
			repeat (depth_q[q]) conv(12'h190, 1'b0);
			conv(12'h190, 1'b0);
			ev(0);
			cfg(3, q, q % 2, 0, 1);
			cfg(3, q, q % 2, 0, 0);
			conv(12'h100, 1'b0);
			repeat (depth_q[q]) conv(12'h0a0, 1'b0);
		end
		$display("test comparator done");
		// Interrupt alternation; the reload now selects interrupt mode
		@(posedge clk_i);
		nv_alarm_behaviour_sel_i <= 1'b1;
		ev(2);
		cfg(3, 1, 0, 1, 0);
		repeat (2) conv(12'h0a0, 1'b0);
		repeat (2) conv(12'h200, 1'b0);
		repeat (5) @(posedge clk_i);
		chk_st();
		ev(0);
		repeat (2) conv(12'h200, 1'b0);
		repeat (2) conv(12'h800, 1'b0);
		ev(1);
		conv(12'h200, 1'b0);
		cfg(3, 1, 0, 1, 1);
		cfg(3, 1, 0, 1, 0);
		$display("test interrupt done");
		// Mode changes with the alarm asserted
		conv(12'h0a0, 1'b0);
		cfg(3, 1, 0, 0, 0);
		ev(0);
		conv(12'h0a0, 1'b0);
		conv(12'h190, 1'b0);
		cfg(3, 1, 0, 1, 0);
		ev(1);
		$display("test mode_switch done");
		// One-shot in shutdown pulses the interrupt alarm
		cfg(3, 1, 1, 1, 1);
		conv(12'h0a0, 1'b1);
		repeat (110) @(posedge clk_i);
		m_act = 0;
		chk_st();
		$display("test one_shot done");
		// General-call reset drops an active alarm and reloads
		cfg(3, 1, 1, 1, 0);
		conv(12'h190, 1'b0);
		ev(2);
		$display("test general_call done");
		final_report();
	end

endmodule
